/* File: fso_pkg.sv */
package fso_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [15:0] FSO_FW_OFFSET = 16'h0010;
   localparam logic [19:0] FSO_HOST_OFFSET = 20'h05B54;
   localparam logic [31:0] FSO_RESET_VALUE = 32'h0000_0040;
   localparam logic [31:0] FSO_IMPL_MASK = 32'h0000_BFFF;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int FSO_B_FIRMWARE_GRANT_FLAG = 0;
   localparam int FSO_B_WAKE = 1;
   localparam int FSO_B_REMOTE = 2;
   localparam int FSO_B_PROXY = 3;
   localparam int FSO_B_MSGCAP = 4;
   localparam int FSO_B_SRVREQ = 5;
   localparam int FSO_B_PHYRST = 6;
   localparam int FSO_B_LOCK_LO = 7;
   localparam int FSO_B_LOCK_HI = 9;
   localparam int FSO_B_RSVD = 10;
   localparam int FSO_B_LSOWN = 11;
   localparam int FSO_B_LSLOCK = 12;
   localparam int FSO_B_LSACT = 13;
   localparam int FSO_B_FWVAL = 15;
   localparam int FSO_MAC_ENTRIES = 11;
   // ----------------------------------------------------------------
   // arbitration states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FSO_IDLE = 2'b00,
      FSO_WAIT = 2'b01,
      FSO_OWN = 2'b11
   } fso_state_t;
endpackage

/* File: fso_lock_if.sv */
`timescale 1ns/100ps
interface fso_lock_if;
   logic [2:0] code;
   logic [10:0] locked;
   modport ctrl (output code, input locked);
   modport dec (input code, output locked);
endinterface

/* File: fso_lock_dec.sv */
`timescale 1ns/100ps
module fso_lock_dec
   import fso_pkg::*;
(
   fso_lock_if.dec lk
);
   // ----------------------------------------------------------------
   // address lock decode
   // ----------------------------------------------------------------
   logic [3:0] first;
   // duplicate printed code taken as 011 for entries 3..10
   always_comb begin
      unique case (lk.code)
         3'b000: first = 4'hF;
         3'b001: first = 4'h0;
         3'b010: first = 4'h2;
         3'b011: first = 4'h3;
         3'b100: first = 4'h4;
         3'b101: first = 4'h5;
         3'b110: first = 4'h6;
         3'b111: first = 4'h7;
      endcase
   end
   // one compare per entry; code 000 yields a start past the table
   genvar i;
   generate
      for (i = 0; i < FSO_MAC_ENTRIES; i++) begin : g_ent
         assign lk.locked[i] = (4'(i) >= first); // [RULE13]
      end
   endgenerate
endmodule

/* File: fso_top.sv */
`timescale 1ns/100ps
// Summary of operation
// [RULE1] firmware reads/writes the register; host sees an identical read-only mirror
// [RULE2] contents load defaults only on lan power-good reset, not other resets
// [RULE3] firmware flag granted only when software flag clear and mdio idle
// [RULE4] firmware writes flag, polls until set, then uses shared resources
// [RULE5] firmware clears the flag when finished with shared resources
// [RULE6] bit 1 firmware-writable: engine caused last host wake
// [RULE7] firmware clears the wake indication before sleep entry
// [RULE8] bits 2,3 support flags, valid only while firmware-valid set
// [RULE9] bit 4 firmware flag: engine messaging capable
// [RULE10] bit 5 firmware service request to give up mailbox
// [RULE11] bit 6 resets to 1; enables phy reset on host or software reset
// [RULE12] firmware clears bit 6 to keep link across host resets
// [RULE13] bits 9:7 select write-locked shared mac address entries
// [RULE14] firmware programs lock field after configuring its mac entries
// [RULE15] bit 11 link security owner, 1 means engine, reset 0
// [RULE16] link security interrupts go to engine when owner set, else host
// [RULE17] engine may release link security after host request bit
// [RULE18] bit 12 set: host link security reads undefined, writes dropped
// [RULE19] blocked host accesses still complete without error
// [RULE20] firmware sets bit 13 with secure channel, clears on close
// [RULE21] firmware-valid cleared by management function or software reset; the code clears it on management function reset only
// [RULE22] register 32 bits; reserved bit 10 stores writes, no effect
module fso_top
   import fso_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic fw_wr,
   input wire logic fw_rd,
   input wire logic [15:0] fw_addr,
   input wire logic [31:0] fw_wdata,
   output logic [31:0] fw_rdata,
   output logic fw_rvalid,
   input wire logic host_rd,
   input wire logic [19:0] host_addr,
   output logic [31:0] host_rdata,
   output logic host_rvalid,
   input wire logic sw_flag,
   input wire logic hw_mdio_busy,
   input wire logic mgmt_fn_reset,
   input wire logic host_pci_reset,
   input wire logic sw_phy_reset,
   input wire logic ls_irq,
   input wire logic ls_host_rd,
   input wire logic ls_host_wr,
   input wire logic [31:0] ls_rdata_raw,
   output logic ls_irq_engine,
   output logic ls_irq_host,
   output logic [31:0] ls_host_rdata,
   output logic ls_host_wr_en,
   output logic ls_host_done,
   output logic phy_reset_req,
   output logic [10:0] mac_lock
);
   // ----------------------------------------------------------------
   // input synchronisers for pin-level signals
   // ----------------------------------------------------------------
   logic [1:0] swf_s, mdio_s, mfr_s, pci_s, spr_s;
   always_ff @(posedge mclk) begin
      swf_s <= {swf_s[0], sw_flag};
      mdio_s <= {mdio_s[0], hw_mdio_busy};
      mfr_s <= {mfr_s[0], mgmt_fn_reset};
      pci_s <= {pci_s[0], host_pci_reset};
      spr_s <= {spr_s[0], sw_phy_reset};
   end
   // ----------------------------------------------------------------
   // semaphore register and flag arbitration
   // ----------------------------------------------------------------
   logic [31:0] reg_q, reg_d;
   fso_state_t st_q, st_d;
   logic fw_hit;
   logic [31:0] wval;
   assign fw_hit = fw_wr && (fw_addr == FSO_FW_OFFSET);
   // rst stands for lan power-good only; host resets never reach here
   always_comb begin
      reg_d = reg_q;
      st_d = st_q;
      wval = fw_wdata & FSO_IMPL_MASK;
      if (fw_hit) begin
         reg_d = wval; // [RULE1] [RULE6] [RULE8] [RULE9] [RULE10] [RULE15] [RULE22]
         reg_d[FSO_B_FIRMWARE_GRANT_FLAG] = reg_q[FSO_B_FIRMWARE_GRANT_FLAG] && wval[FSO_B_FIRMWARE_GRANT_FLAG];
         st_d = wval[FSO_B_FIRMWARE_GRANT_FLAG] ? ((st_q == FSO_OWN) ? FSO_OWN : FSO_WAIT) : FSO_IDLE;
      end
      // grant is held off while software or hardware uses mdio
      if (st_d == FSO_WAIT && !swf_s[1] && !mdio_s[1]) begin
         st_d = FSO_OWN; // [RULE3]
      end
      reg_d[FSO_B_FIRMWARE_GRANT_FLAG] = (st_d == FSO_OWN); // [RULE3]
      // hardware clear of valid loses to nothing but a firmware set later
      if (mfr_s[1]) begin
         reg_d[FSO_B_FWVAL] = 1'b0; // [RULE21]
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_q <= FSO_RESET_VALUE; // [RULE2]
         st_q <= FSO_IDLE;
      end else begin
         reg_q <= reg_d;
         st_q <= st_d;
      end
   end
   // ----------------------------------------------------------------
   // address lock decode
   // ----------------------------------------------------------------
   fso_lock_if lk ();
   assign lk.code = reg_q[FSO_B_LOCK_HI:FSO_B_LOCK_LO];
   fso_lock_dec u_dec (
      .lk(lk)
   );
   // ----------------------------------------------------------------
   // read ports, routing and link security gating
   // ----------------------------------------------------------------
   logic [31:0] frd_d, hrd_d, lsr_d;
   logic lsw_d, lsdone_d, prst_d;
   always_comb begin
      frd_d = (fw_addr == FSO_FW_OFFSET) ? reg_q : 32'h0000_0000;
      hrd_d = (host_addr == FSO_HOST_OFFSET) ? reg_q : 32'h0000_0000; // [RULE1]
      // locked reads return zero, a fixed stand-in for undefined data
      lsr_d = reg_q[FSO_B_LSLOCK] ? 32'h0000_0000 : ls_rdata_raw; // [RULE18]
      lsw_d = ls_host_wr && !reg_q[FSO_B_LSLOCK]; // [RULE18]
      lsdone_d = ls_host_rd || ls_host_wr; // [RULE19]
      prst_d = reg_q[FSO_B_PHYRST] && (pci_s[1] || spr_s[1]); // [RULE11]
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         fw_rdata <= 32'h0000_0000;
         fw_rvalid <= 1'b0;
         host_rdata <= 32'h0000_0000;
         host_rvalid <= 1'b0;
         ls_irq_engine <= 1'b0;
         ls_irq_host <= 1'b0;
         ls_host_rdata <= 32'h0000_0000;
         ls_host_wr_en <= 1'b0;
         ls_host_done <= 1'b0;
         phy_reset_req <= 1'b0;
         mac_lock <= 11'h000;
      end else begin
         fw_rdata <= frd_d;
         fw_rvalid <= fw_rd;
         host_rdata <= hrd_d;
         host_rvalid <= host_rd;
         ls_irq_engine <= ls_irq && reg_q[FSO_B_LSOWN]; // [RULE16]
         ls_irq_host <= ls_irq && !reg_q[FSO_B_LSOWN]; // [RULE16]
         ls_host_rdata <= lsr_d;
         ls_host_wr_en <= lsw_d;
         ls_host_done <= lsdone_d;
         phy_reset_req <= prst_d;
         mac_lock <= lk.locked; // [RULE13]
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_grant_clear;
      @(posedge mclk) disable iff (rst)
         (swf_s[1] || mdio_s[1]) && !reg_q[FSO_B_FIRMWARE_GRANT_FLAG] |=> !reg_q[FSO_B_FIRMWARE_GRANT_FLAG];
   endproperty
   a_grant_clear: assert property (p_grant_clear) else $error("granted while busy"); // [RULE3]
   property p_grant_come;
      @(posedge mclk) disable iff (rst)
         st_q == FSO_WAIT && !swf_s[1] && !mdio_s[1] && !fw_hit |=> reg_q[FSO_B_FIRMWARE_GRANT_FLAG];
   endproperty
   a_grant_come: assert property (p_grant_come) else $error("flag not granted"); // [RULE3]
   property p_mirror;
      @(posedge mclk) disable iff (rst)
         host_addr == FSO_HOST_OFFSET |=> host_rdata == $past(reg_q);
   endproperty
   a_mirror: assert property (p_mirror) else $error("host mirror differs"); // [RULE1]
   property p_irq_route;
      @(posedge mclk) disable iff (rst)
         ls_irq |=> (ls_irq_engine == $past(reg_q[FSO_B_LSOWN])) && (ls_irq_host != ls_irq_engine);
   endproperty
   a_irq_route: assert property (p_irq_route) else $error("irq misrouted"); // [RULE16]
   property p_ls_block;
      @(posedge mclk) disable iff (rst)
         reg_q[FSO_B_LSLOCK] && ls_host_wr |=> !ls_host_wr_en && ls_host_done;
   endproperty
   a_ls_block: assert property (p_ls_block) else $error("locked write passed"); // [RULE18]
   property p_done;
      @(posedge mclk) disable iff (rst)
         ls_host_rd |=> ls_host_done;
   endproperty
   a_done: assert property (p_done) else $error("access not completed"); // [RULE19]
   property p_phy;
      @(posedge mclk) disable iff (rst)
         !reg_q[FSO_B_PHYRST] |=> !phy_reset_req;
   endproperty
   a_phy: assert property (p_phy) else $error("phy reset while disabled"); // [RULE11]
   property p_fwval;
      @(posedge mclk) disable iff (rst)
         mfr_s[1] |=> !reg_q[FSO_B_FWVAL];
   endproperty
   a_fwval: assert property (p_fwval) else $error("valid not cleared"); // [RULE21]
   property p_rsvd;
      @(posedge mclk) disable iff (rst)
         fw_hit |=> reg_q[FSO_B_RSVD] == $past(fw_wdata[FSO_B_RSVD]);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit not stored"); // [RULE22]
endmodule

/* File: fso_sw_peer.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host driver side of the mdio arbitration
// ---------------------------------------------------------------
module fso_sw_peer (
   input wire logic mclk,
   input wire logic sw_want,
   input wire logic mdio_want,
   output logic sw_flag,
   output logic hw_mdio_busy
);
   // levels move only after the falling edge, away from the device's sampling edge
   initial begin
      sw_flag = 1'b0;
      hw_mdio_busy = 1'b0;
   end
   always @(negedge mclk) begin
      sw_flag <= sw_want;
      hw_mdio_busy <= mdio_want;
   end
endmodule

/* File: fso_top_tb.sv */
`timescale 1ns/100ps
module fso_top_tb;
   import fso_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic mclk = 0, rst = 1, fw_wr = 0, fw_rd = 0, host_rd = 0, sw_want = 0, mdio_want = 0;
   logic mgmt_fn_reset = 0, host_pci_reset = 0, sw_phy_reset = 0, ls_irq = 0;
   logic ls_host_rd = 0, ls_host_wr = 0, sw_flag, hw_mdio_busy, fw_rvalid, host_rvalid;
   logic ls_irq_engine, ls_irq_host, ls_host_wr_en, ls_host_done, phy_reset_req;
   logic [15:0] fw_addr = 16'h0000;
   logic [19:0] host_addr = 20'h00000;
   logic [31:0] fw_wdata = 32'h0, ls_rdata_raw = 32'h1234_5678, fw_rdata, host_rdata, v;
   logic [31:0] ls_host_rdata;
   logic [10:0] mac_lock;
   int bad_count = 0, num_checks = 0, i, c;
   // locked entry masks, one per lock code
   logic [10:0] exp_lock [8] = '{11'h000, 11'h7FF, 11'h7FC, 11'h7F8,
                                 11'h7F0, 11'h7E0, 11'h7C0, 11'h780};
   always #2 mclk = ~mclk;
   fso_sw_peer peer_u (.mclk(mclk), .sw_want(sw_want), .mdio_want(mdio_want),
                       .sw_flag(sw_flag), .hw_mdio_busy(hw_mdio_busy));
   fso_top dut_u (.mclk(mclk), .rst(rst), .fw_wr(fw_wr), .fw_rd(fw_rd), .fw_addr(fw_addr),
      .fw_wdata(fw_wdata), .fw_rdata(fw_rdata), .fw_rvalid(fw_rvalid), .host_rd(host_rd),
      .host_addr(host_addr), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .sw_flag(sw_flag), .hw_mdio_busy(hw_mdio_busy), .mgmt_fn_reset(mgmt_fn_reset),
      .host_pci_reset(host_pci_reset), .sw_phy_reset(sw_phy_reset), .ls_irq(ls_irq),
      .ls_host_rd(ls_host_rd), .ls_host_wr(ls_host_wr), .ls_rdata_raw(ls_rdata_raw),
      .ls_irq_engine(ls_irq_engine), .ls_irq_host(ls_irq_host),
      .ls_host_rdata(ls_host_rdata), .ls_host_wr_en(ls_host_wr_en),
      .ls_host_done(ls_host_done), .phy_reset_req(phy_reset_req), .mac_lock(mac_lock));
   // ---------------------------------------------------------------
   // verdict, compare and access tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // a lost answer is a mismatch and ends the run
   task automatic give_up(input int n);
      if (n >= 6) begin
         bad_count++;
         close_out();
      end
   endtask
   task automatic fw_write(input logic [31:0] d);
      @(negedge mclk);
      fw_wr = 1'b1;
      fw_addr = FSO_FW_OFFSET;
      fw_wdata = d;
      @(negedge mclk);
      fw_wr = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   // host=1 uses the read-only mirror path, host=0 the firmware port
   task automatic rd(input bit host, input logic [19:0] a, output logic [31:0] d);
      int n;
      @(negedge mclk);
      host_rd = host;
      fw_rd = !host;
      host_addr = a;
      fw_addr = a[15:0];
      @(negedge mclk);
      host_rd = 1'b0;
      fw_rd = 1'b0;
      for (n = 0; n < 6 && (host ? host_rvalid : fw_rvalid) !== 1'b1; n++) @(negedge mclk);
      give_up(n);
      d = host ? host_rdata : fw_rdata;
   endtask
   // one host access to the link security space; data and write enable taken at completion
   task automatic ls_acc(input bit wr, input logic [31:0] exp_d, input logic exp_en);
      int n;
      @(negedge mclk);
      ls_host_rd = !wr;
      ls_host_wr = wr;
      @(negedge mclk);
      ls_host_rd = 1'b0;
      ls_host_wr = 1'b0;
      for (n = 0; n < 6 && ls_host_done !== 1'b1; n++) @(negedge mclk);
      give_up(n);
      if (wr) chk(32'(ls_host_wr_en), 32'(exp_en));
      else chk(ls_host_rdata, exp_d);
   endtask
   // the phy reset request must follow either reset source while bit 6 is set
   task automatic phy_try(input logic exp);
      for (c = 0; c < 2; c++) begin
         @(negedge mclk);
         host_pci_reset = (c == 0);
         sw_phy_reset = (c == 1);
         // two sync stages and the output flop; a fixed wait also makes the quiet case count
         repeat (4) @(negedge mclk);
         chk(32'(phy_reset_req), 32'(exp));
         host_pci_reset = 1'b0;
         sw_phy_reset = 1'b0;
         repeat (6) @(negedge mclk);
      end
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0040);
      rd(1, FSO_HOST_OFFSET, v);
      chk(v, 32'h0000_0040);
      rd(0, 20'h00014, v);
      chk(v, 32'h0000_0000);
      phy_try(1'b1);
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0040);
      // grant is held off by the software flag, then by mdio traffic;
      // the flag needs the peer's half cycle and two sync stages before it counts
      sw_want = 1'b1;
      repeat (4) @(negedge mclk);
      fw_write(32'h0000_0041);
      repeat (6) @(negedge mclk);
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0040);
      sw_want = 1'b0;
      mdio_want = 1'b1;
      repeat (6) @(negedge mclk);
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0040);
      mdio_want = 1'b0;
      for (i = 0; i < 10 && v[0] !== 1'b1; i++) rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0041);
      fw_write(32'h0000_0040);
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0040);
      // every writable field but the grant flag at once; unimplemented bits drop
      fw_write(32'hFFFF_FFFE);
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_BFFE);
      rd(1, FSO_HOST_OFFSET, v);
      chk(v, 32'h0000_BFFE);
      ls_irq = 1'b1;
      repeat (3) @(negedge mclk);
      chk({ls_irq_engine, ls_irq_host}, 32'h2);
      ls_acc(0, 32'h0, 1'b0);
      ls_acc(1, 32'h0, 1'b0);
      // engine drops wake, phy reset enable, channel and ownership before host takes over
      fw_write(32'h0000_0000);
      repeat (3) @(negedge mclk);
      chk({ls_irq_engine, ls_irq_host}, 32'h1);
      ls_acc(0, ls_rdata_raw, 1'b1);
      ls_acc(1, 32'h0, 1'b1);
      phy_try(1'b0);
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0000);
      for (int k = 0; k < 8; k++) begin
         fw_write({22'h0, 3'(k), 7'h00});
         chk(32'(mac_lock), 32'(exp_lock[k]));
      end
      // management reset clears only the valid bit; bit 2 stays but means nothing now
      fw_write(32'h0000_8046);
      @(negedge mclk);
      mgmt_fn_reset = 1'b1;
      repeat (4) @(negedge mclk);
      mgmt_fn_reset = 1'b0;
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0046);
      // a second power-good reset in mid-run brings the default back
      @(negedge mclk);
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      rd(0, 20'(FSO_FW_OFFSET), v);
      chk(v, 32'h0000_0040);
      rd(1, FSO_HOST_OFFSET, v);
      chk(v, 32'h0000_0040);
      close_out();
   end
   // run limit guards against a hung handshake
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      close_out();
   end
endmodule
